// *** rtl/plprt_pkg.sv ***
// Package with register map, field positions and reset values of the link, power and reflectometry bank.
// Contract
// - Link status shows link established at bit 15, link lost at bit 14, descrambler lock, local and remote receiver status at bits 2..0, all reset to zero.
// - Link status shows the send-data state of the control machine at bit 13 and overall link state at bit 12, read-only.
// - Bit 8 of the low-power configuration enables energy detection on the line, reset zero.
// - Sleep may be entered only while bit 7 of the low-power configuration is one; with the override enable set, bit 0 of the force values permits it instead.
// - Bit 6 of the low-power configuration selects normal mode after power-up when one and standby when zero; the bit resets to zero, so power-up is standby.
// - Writing one to bit 4 of the power-mode command requests standby and the bit clears itself.
// - Writing one to bit 0 of the power-mode command requests normal mode and the bit clears itself once taken; it clears next cycle, taken or not.
// - Three reflectometry registers report five 8-bit peak locations in the documented byte lanes.
// - The first peak amplitude sits in bits 15-8 of the third result register and five peak signs in bits 4-0 of a separate register.
// - A 6-bit line-driver swing code in bits 15-10 resets to 19h.
// - When the override enable is one the energy detect, sleep enable and energy lost controls come from the force values instead of the device logic.
// - A 2-bit serial output swing field at bits 14-13 resets to 3h.
// - Bit 11 of the serial output configuration selects the slow edge rate, reset zero.
package plprt_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [11:0] ADDR_LINK_STATUS  = 12'h180;
  localparam logic [11:0] ADDR_LP_CONFIG    = 12'h18B;
  localparam logic [11:0] ADDR_PWR_CMD      = 12'h18C;
  localparam logic [11:0] ADDR_PEAK_LOW     = 12'h309;
  localparam logic [11:0] ADDR_PEAK_MID     = 12'h30A;
  localparam logic [11:0] ADDR_PEAK_AMP     = 12'h30B;
  localparam logic [11:0] ADDR_PEAK_SIGNS   = 12'h30E;
  localparam logic [11:0] ADDR_FAULT_SUM    = 12'h30F;
  localparam logic [11:0] ADDR_LD_SWING     = 12'h405;
  localparam logic [11:0] ADDR_FORCE_EN     = 12'h41E;
  localparam logic [11:0] ADDR_MISC_CFG     = 12'h41F;
  localparam logic [11:0] ADDR_SER_OUT_CFG  = 12'h428;
  localparam logic [11:0] ADDR_FORCE_VAL    = 12'h42F;
  localparam logic [11:0] ADDR_IRQ_STATUS   = 12'h440;
  localparam logic [11:0] ADDR_IRQ_MASK     = 12'h441;

  // ==========================================================================
  // Field positions.
  localparam int BIT_ENERGY_DET   = 8;
  localparam int BIT_SLEEP_ALLOW  = 7;
  localparam int BIT_AUTO_MODE    = 6;
  localparam int BIT_CMD_STANDBY  = 4;
  localparam int BIT_CMD_NORMAL   = 0;
  localparam int BIT_OVERRIDE_EN  = 8;
  localparam int BIT_EDGE_RATE    = 11;
  localparam int SWING_LSB        = 10;
  localparam int SER_SWING_LSB    = 13;
  localparam int BIT_LINK_UP      = 15;
  localparam int BIT_LINK_LOST    = 14;
  localparam int BIT_FORCE_SLEEP  = 0;
  localparam int BIT_FORCE_ENERGY = 1;
  localparam int BIT_FORCE_LOST   = 2;

  // Writable masks, plus the read mask of the fault summary; bits outside a mask are read-only, while swing, misc and serial output registers are written whole.
  localparam logic [15:0] MASK_LP_CONFIG  = 16'h01FF;
  localparam logic [15:0] MASK_PWR_CMD    = 16'h00FF;
  localparam logic [15:0] MASK_FORCE_EN   = 16'h01FF;
  localparam logic [15:0] MASK_FORCE_VAL  = 16'hFFFF;
  localparam logic [15:0] MASK_IRQ        = 16'h000F;
  localparam logic [15:0] MASK_FAULT_SUM  = 16'h3FF3;

  // ==========================================================================
  // Reset values.
  localparam logic [15:0] RST_ZERO        = 16'h0000;
  localparam logic [15:0] RST_LD_SWING    = 16'h6400;
  localparam logic [15:0] RST_SER_OUT     = 16'h6002;

  // Interrupt event positions.
  localparam int IRQ_LINK_UP   = 0;
  localparam int IRQ_LINK_DOWN = 1;
  localparam int IRQ_MODE_CHG  = 2;
  localparam int IRQ_SLEEP     = 3;

  // Power modes.
  typedef enum logic [1:0] {PM_STANDBY, PM_NORMAL, PM_SLEEP} plprt_mode_t;

endpackage

// *** rtl/plprt_regs.sv ***
// Register bank for link status, low-power control, reflectometry results and analog trims.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
module plprt_regs
  import plprt_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Register port.
  input  wire logic [11:0] regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  // Link state inputs.
  input  wire logic        linkUp,
  input  wire logic        linkDown,
  input  wire logic        sendData,
  input  wire logic        linkStatus,
  input  wire logic        descrLock,
  input  wire logic        localRcvr,
  input  wire logic        remoteRcvr,
  // Reflectometry results.
  input  wire logic [39:0] peakPositions,
  input  wire logic [7:0]  firstPeakAmplitude,
  input  wire logic [4:0]  peakPolarity,
  input  wire logic [15:0] faultSummary,
  // Power events from the analog front end.
  input  wire logic        sleepRequest,
  input  wire logic        energyLostIn,
  input  wire logic        wakeRequest,
  // Analog controls.
  output logic             energyDetectEnable,
  output logic             sleepEnable,
  output logic             energyLost,
  output logic [1:0]       powerMode,
  output logic [5:0]       lineDriverSwingCode,
  output logic [1:0]       serialOutSwingSel,
  output logic             serialOutEdgeRate,
  // Interrupt.
  output logic             irq
);

  // ==========================================================================
  // Storage.
  logic [15:0] lpConfig_q;
  logic [15:0] pwrCmd_q;
  logic [15:0] ldSwing_q;
  logic [15:0] forceEn_q;
  logic [15:0] miscCfg_q;
  logic [15:0] serOut_q;
  logic [15:0] forceVal_q;
  logic [15:0] linkStat_q;
  logic [15:0] irqStatus_q;
  logic [15:0] irqMask_q;
  plprt_mode_t mode_q;
  plprt_mode_t mode_d;
  logic        powerUp_q;
  logic        sleepGate;
  logic [3:0]  events;

  // Address hit decoding used by every register.
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  // Link status capture; read-only for software.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      linkStat_q <= RST_ZERO;
    end else begin
      linkStat_q <= {linkUp, linkDown, sendData, linkStatus, 9'h000,
                     descrLock, localRcvr, remoteRcvr};
    end
  end

  // Low-power configuration; bits 15-9 are read-only zero.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lpConfig_q <= RST_ZERO;
    end else if (regWr && hit(regAddr, ADDR_LP_CONFIG)) begin
      lpConfig_q <= regWdata & MASK_LP_CONFIG;
    end
  end

  // Command bits set by software and cleared the cycle after the write, whether the mode machine takes them or not.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwrCmd_q <= RST_ZERO;
    end else if (regWr && hit(regAddr, ADDR_PWR_CMD)) begin
      pwrCmd_q <= regWdata & MASK_PWR_CMD;
    end else begin
      pwrCmd_q <= RST_ZERO;
    end
  end

  // Analog trim and force registers.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ldSwing_q  <= RST_LD_SWING;
      forceEn_q  <= RST_ZERO;
      miscCfg_q  <= RST_ZERO;
      serOut_q   <= RST_SER_OUT;
      forceVal_q <= RST_ZERO;
    end else if (regWr) begin
      if (hit(regAddr, ADDR_LD_SWING)) begin
        ldSwing_q <= regWdata;
      end else if (hit(regAddr, ADDR_FORCE_EN)) begin
        forceEn_q <= regWdata & MASK_FORCE_EN;
      end else if (hit(regAddr, ADDR_MISC_CFG)) begin
        miscCfg_q <= regWdata;
      end else if (hit(regAddr, ADDR_SER_OUT_CFG)) begin
        serOut_q <= regWdata;
      end else if (hit(regAddr, ADDR_FORCE_VAL)) begin
        forceVal_q <= regWdata & MASK_FORCE_VAL;
      end
    end
  end

  // Sleep is only allowed by the configuration bit, or by the forced value.
  always_comb begin
    if (forceEn_q[BIT_OVERRIDE_EN]) begin
      sleepGate = forceVal_q[BIT_FORCE_SLEEP];
    end else begin
      sleepGate = lpConfig_q[BIT_SLEEP_ALLOW];
    end
  end

  // Power mode machine; commands change the mode two cycles after the write.
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      PM_STANDBY: begin
        if (pwrCmd_q[BIT_CMD_NORMAL]) begin
          mode_d = PM_NORMAL;
        end
      end
      PM_NORMAL: begin
        if (pwrCmd_q[BIT_CMD_STANDBY]) begin
          mode_d = PM_STANDBY;
        end else if (sleepRequest && sleepGate) begin
          mode_d = PM_SLEEP;
        end
      end
      PM_SLEEP: begin
        if (wakeRequest) begin
          mode_d = PM_NORMAL;
        end
      end
      default: begin
        mode_d = PM_STANDBY;
      end
    endcase
  end

  // Mode register; the first cycle after reset picks the power-up mode.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q    <= PM_STANDBY;
      powerUp_q <= 1'b1;
    end else if (powerUp_q) begin
      powerUp_q <= 1'b0;
      mode_q    <= lpConfig_q[BIT_AUTO_MODE] ? PM_NORMAL : PM_STANDBY;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Interrupt events.
  assign events[IRQ_LINK_UP]   = linkUp && !linkStat_q[BIT_LINK_UP];
  assign events[IRQ_LINK_DOWN] = linkDown && !linkStat_q[BIT_LINK_LOST];
  assign events[IRQ_MODE_CHG]  = (mode_d != mode_q) && !powerUp_q;
  assign events[IRQ_SLEEP]     = (mode_d == PM_SLEEP) && (mode_q != PM_SLEEP);

  // Sticky status, write one to clear; a new event wins over the clear.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqStatus_q <= RST_ZERO;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (events[i]) begin
          irqStatus_q[i] <= 1'b1;
        end else if (regWr && hit(regAddr, ADDR_IRQ_STATUS) && regWdata[i]) begin
          irqStatus_q[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt mask.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqMask_q <= RST_ZERO;
    end else if (regWr && hit(regAddr, ADDR_IRQ_MASK)) begin
      irqMask_q <= regWdata & MASK_IRQ;
    end
  end

  // Registered outputs toward the analog blocks.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      energyDetectEnable  <= 1'b0;
      sleepEnable         <= 1'b0;
      energyLost          <= 1'b0;
      powerMode           <= 2'h0;
      lineDriverSwingCode <= RST_LD_SWING[SWING_LSB +: 6];
      serialOutSwingSel   <= RST_SER_OUT[SER_SWING_LSB +: 2];
      serialOutEdgeRate   <= 1'b0;
      irq                 <= 1'b0;
    end else begin
      energyDetectEnable  <= forceEn_q[BIT_OVERRIDE_EN] ? forceVal_q[BIT_FORCE_ENERGY]
                             : lpConfig_q[BIT_ENERGY_DET];
      sleepEnable         <= sleepGate;
      energyLost          <= forceEn_q[BIT_OVERRIDE_EN] ? forceVal_q[BIT_FORCE_LOST]
                             : energyLostIn;
      powerMode           <= mode_q;
      lineDriverSwingCode <= ldSwing_q[SWING_LSB +: 6];
      serialOutSwingSel   <= serOut_q[SER_SWING_LSB +: 2];
      serialOutEdgeRate   <= serOut_q[BIT_EDGE_RATE];
      irq                 <= |(irqStatus_q & irqMask_q);
    end
  end

  // Read port; data stand in the cycle after the strobe.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdata <= RST_ZERO;
    end else if (regRd) begin
      if (hit(regAddr, ADDR_LINK_STATUS)) begin
        regRdata <= linkStat_q;
      end else if (hit(regAddr, ADDR_LP_CONFIG)) begin
        regRdata <= lpConfig_q;
      end else if (hit(regAddr, ADDR_PWR_CMD)) begin
        regRdata <= pwrCmd_q;
      end else if (hit(regAddr, ADDR_PEAK_LOW)) begin
        regRdata <= peakPositions[15:0];
      end else if (hit(regAddr, ADDR_PEAK_MID)) begin
        regRdata <= peakPositions[31:16];
      end else if (hit(regAddr, ADDR_PEAK_AMP)) begin
        regRdata <= {firstPeakAmplitude, peakPositions[39:32]};
      end else if (hit(regAddr, ADDR_PEAK_SIGNS)) begin
        regRdata <= {11'h000, peakPolarity};
      end else if (hit(regAddr, ADDR_FAULT_SUM)) begin
        regRdata <= faultSummary & MASK_FAULT_SUM;
      end else if (hit(regAddr, ADDR_LD_SWING)) begin
        regRdata <= ldSwing_q;
      end else if (hit(regAddr, ADDR_FORCE_EN)) begin
        regRdata <= forceEn_q;
      end else if (hit(regAddr, ADDR_MISC_CFG)) begin
        regRdata <= miscCfg_q;
      end else if (hit(regAddr, ADDR_SER_OUT_CFG)) begin
        regRdata <= serOut_q;
      end else if (hit(regAddr, ADDR_FORCE_VAL)) begin
        regRdata <= forceVal_q;
      end else if (hit(regAddr, ADDR_IRQ_STATUS)) begin
        regRdata <= irqStatus_q;
      end else if (hit(regAddr, ADDR_IRQ_MASK)) begin
        regRdata <= irqMask_q;
      end else begin
        regRdata <= RST_ZERO;
      end
    end
  end

  // ==========================================================================
  // Assertions.
  property p_link_flags;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |=> (linkStat_q[15] == $past(linkUp)) && (linkStat_q[2] == $past(descrLock));
  endproperty
  a_link_flags: assert property (p_link_flags) else $error("link flags wrong");

  property p_send_data;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |=> (linkStat_q[13:12] == {$past(sendData), $past(linkStatus)});
  endproperty
  a_send_data: assert property (p_send_data) else $error("send data flag wrong");

  property p_energy;
    @(posedge clk_sys) disable iff (rst)
      !forceEn_q[BIT_OVERRIDE_EN] |=> energyDetectEnable == $past(lpConfig_q[BIT_ENERGY_DET]);
  endproperty
  a_energy: assert property (p_energy) else $error("energy detect wrong");

  property p_no_sleep;
    @(posedge clk_sys) disable iff (rst)
      (mode_q != PM_SLEEP) && !sleepGate |=> mode_q != PM_SLEEP;
  endproperty
  a_no_sleep: assert property (p_no_sleep) else $error("sleep without permit");

  property p_powerup;
    @(posedge clk_sys) disable iff (rst)
      powerUp_q |=> mode_q == ($past(lpConfig_q[BIT_AUTO_MODE]) ? PM_NORMAL : PM_STANDBY);
  endproperty
  a_powerup: assert property (p_powerup) else $error("power-up mode wrong");

  property p_standby_cmd;
    @(posedge clk_sys) disable iff (rst)
      regWr && hit(regAddr, ADDR_PWR_CMD) && regWdata[BIT_CMD_STANDBY] && mode_q == PM_NORMAL
      && !powerUp_q |=> ##1 (mode_q == PM_STANDBY) && !pwrCmd_q[BIT_CMD_STANDBY];
  endproperty
  a_standby_cmd: assert property (p_standby_cmd) else $error("standby cmd lost");

  property p_normal_cmd;
    @(posedge clk_sys) disable iff (rst)
      pwrCmd_q[BIT_CMD_NORMAL] && !(regWr && hit(regAddr, ADDR_PWR_CMD))
      |=> !pwrCmd_q[BIT_CMD_NORMAL];
  endproperty
  a_normal_cmd: assert property (p_normal_cmd) else $error("normal cmd stuck");

  property p_signs_read;
    @(posedge clk_sys) disable iff (rst)
      regRd && hit(regAddr, ADDR_PEAK_SIGNS) |=> regRdata == {11'h000, $past(peakPolarity)};
  endproperty
  a_signs_read: assert property (p_signs_read) else $error("sign read wrong");

  property p_swing;
    @(posedge clk_sys) disable iff (rst)
      regWr && hit(regAddr, ADDR_LD_SWING) |=> ##1 lineDriverSwingCode == $past(regWdata[15:10], 2);
  endproperty
  a_swing: assert property (p_swing) else $error("swing code wrong");

  property p_ro_write;
    @(posedge clk_sys) disable iff (rst)
      regWr && hit(regAddr, ADDR_LP_CONFIG) |=> lpConfig_q[15:9] == 7'h00;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only bits written");

  property p_link_lost;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |=> (linkStat_q[BIT_LINK_LOST] == $past(linkDown))
               && (linkStat_q[1:0] == {$past(localRcvr), $past(remoteRcvr)});
  endproperty
  a_link_lost: assert property (p_link_lost) else $error("link lost flags wrong");

  property p_normal_take;
    @(posedge clk_sys) disable iff (rst)
      pwrCmd_q[BIT_CMD_NORMAL] && (mode_q == PM_STANDBY) && !powerUp_q
      |=> mode_q == PM_NORMAL;
  endproperty
  a_normal_take: assert property (p_normal_take) else $error("normal cmd not taken");

  property p_peak_read;
    @(posedge clk_sys) disable iff (rst)
      regRd && hit(regAddr, ADDR_PEAK_LOW) |=> regRdata == $past(peakPositions[15:0]);
  endproperty
  a_peak_read: assert property (p_peak_read) else $error("peak location read wrong");

  property p_amp_read;
    @(posedge clk_sys) disable iff (rst)
      regRd && hit(regAddr, ADDR_PEAK_AMP)
      |=> regRdata == {$past(firstPeakAmplitude), $past(peakPositions[39:32])};
  endproperty
  a_amp_read: assert property (p_amp_read) else $error("peak amplitude read wrong");

  property p_override;
    @(posedge clk_sys) disable iff (rst)
      forceEn_q[BIT_OVERRIDE_EN] |=> (sleepEnable == $past(forceVal_q[BIT_FORCE_SLEEP]))
      && (energyLost == $past(forceVal_q[BIT_FORCE_LOST]));
  endproperty
  a_override: assert property (p_override) else $error("force values ignored");

  property p_ser_swing;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |=> serialOutSwingSel == $past(serOut_q[SER_SWING_LSB +: 2]);
  endproperty
  a_ser_swing: assert property (p_ser_swing) else $error("serial swing wrong");

  property p_edge_rate;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |=> serialOutEdgeRate == $past(serOut_q[BIT_EDGE_RATE]);
  endproperty
  a_edge_rate: assert property (p_edge_rate) else $error("edge rate wrong");

  property p_cmd_ro;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |-> pwrCmd_q[15:8] == 8'h00;
  endproperty
  a_cmd_ro: assert property (p_cmd_ro) else $error("reserved command bits set");

  c_sleep: cover property (@(posedge clk_sys) disable iff (rst) mode_q == PM_SLEEP);
  c_normal: cover property (@(posedge clk_sys) disable iff (rst) mode_q == PM_NORMAL);
  c_irq: cover property (@(posedge clk_sys) disable iff (rst) irq);
  c_override: cover property (@(posedge clk_sys) disable iff (rst) forceEn_q[BIT_OVERRIDE_EN]);

endmodule

// *** test/phy_link_power_tdr_regs_tb.sv ***
// Self-checking testbench for the link, power and reflectometry register bank.
`timescale 1ns/10ps
module phy_link_power_tdr_regs_tb
  import plprt_pkg::*;
;
  // ==========================================================================
  // Stimulus and observation signals.
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] regAddr = 12'h000;
  logic [15:0] regWdata = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [15:0] regRdata;
  logic        linkUp = 1'b0, linkDown = 1'b0, sendData = 1'b0, linkStatus = 1'b0;
  logic        descrLock = 1'b0, localRcvr = 1'b0, remoteRcvr = 1'b0;
  logic [39:0] peakPositions = 40'h00_0000_0000;
  logic [7:0]  firstPeakAmplitude = 8'h00;
  logic [4:0]  peakPolarity = 5'h00;
  logic [15:0] faultSummary = 16'h0000;
  logic        sleepRequest = 1'b0, energyLostIn = 1'b0, wakeRequest = 1'b0;
  logic        energyDetectEnable, sleepEnable, energyLost, serialOutEdgeRate, irq;
  logic [1:0]  powerMode, serialOutSwingSel;
  logic [5:0]  lineDriverSwingCode;
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;

  // The bank under test.
  plprt_regs u_plprt_regs (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .linkUp(linkUp), .linkDown(linkDown),
    .sendData(sendData), .linkStatus(linkStatus), .descrLock(descrLock),
    .localRcvr(localRcvr), .remoteRcvr(remoteRcvr), .peakPositions(peakPositions),
    .firstPeakAmplitude(firstPeakAmplitude), .peakPolarity(peakPolarity),
    .faultSummary(faultSummary), .sleepRequest(sleepRequest), .energyLostIn(energyLostIn),
    .wakeRequest(wakeRequest), .energyDetectEnable(energyDetectEnable),
    .sleepEnable(sleepEnable), .energyLost(energyLost), .powerMode(powerMode),
    .lineDriverSwingCode(lineDriverSwingCode), .serialOutSwingSel(serialOutSwingSel),
    .serialOutEdgeRate(serialOutEdgeRate), .irq(irq));

  // Clock of 20 ns period and a cycle counter that cuts a hang short.
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      wrap_up();
    end
  end

  // ==========================================================================
  // Bus tasks and comparisons.
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  // Read data stand in the cycle after the strobe and are taken at the edge that ends it.
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(posedge clk_sys);
    d = regRdata;
  endtask

  task automatic chk_reg(input logic [11:0] a, input logic [15:0] exp);
    logic [15:0] got;
    rd(a, got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("BAD %0t read %h got %h expected %h", $time, a, got, exp);
    end
  endtask

  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Waits n edges; outputs read there still show the values settled before the edge.
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Polls the power mode for a bounded time, then compares it.
  task automatic wait_mode(input logic [1:0] exp);
    for (int i = 0; i < 20 && powerMode !== exp; i++) settle(1);
    chk_out({6'h00, powerMode}, {6'h00, exp}, "powerMode");
  endtask

  task automatic wrap_up();
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Test sequence.
  logic [11:0] rAddr [16] = '{ADDR_LINK_STATUS, ADDR_LP_CONFIG, ADDR_PWR_CMD, ADDR_PEAK_LOW,
    ADDR_PEAK_MID, ADDR_PEAK_AMP, ADDR_PEAK_SIGNS, ADDR_FAULT_SUM, ADDR_LD_SWING, ADDR_FORCE_EN,
    ADDR_MISC_CFG, ADDR_SER_OUT_CFG, ADDR_FORCE_VAL, ADDR_IRQ_STATUS, ADDR_IRQ_MASK, 12'h123};
  logic [15:0] rVal [16] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h6400, 16'h0000, 16'h0000, 16'h6002, 16'h0000, 16'h0000, 16'h0000,
    16'h0000};

  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    settle(1);
    // Reset values of every register, an unmapped place among them.
    for (int i = 0; i < 16; i++) chk_reg(rAddr[i], rVal[i]);
    chk_out({2'h0, lineDriverSwingCode}, 8'h19, "swing reset");
    chk_out({6'h00, serialOutSwingSel}, 8'h03, "serial swing reset");
    chk_out({7'h00, serialOutEdgeRate}, 8'h00, "edge rate reset");
    chk_out({6'h00, powerMode}, 8'h00, "standby after power-up");
    // Interrupt: a link-up event is held while masked, then raised and cleared.
    wr(ADDR_IRQ_STATUS, 16'h000F);
    linkUp <= 1'b1;
    settle(3);
    chk_out({7'h00, irq}, 8'h00, "irq masked");
    chk_reg(ADDR_IRQ_STATUS, 16'h0001);
    wr(ADDR_IRQ_MASK, 16'h0001);
    settle(3);
    chk_out({7'h00, irq}, 8'h01, "irq unmasked");
    wr(ADDR_IRQ_STATUS, 16'h0001);
    settle(3);
    chk_out({7'h00, irq}, 8'h00, "irq cleared");
    chk_reg(ADDR_IRQ_STATUS, 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h0000);
    // Link flags, and writes to a read-only register.
    {linkDown, sendData, linkStatus} <= 3'b111;
    {descrLock, localRcvr, remoteRcvr} <= 3'b101;
    settle(2);
    chk_reg(ADDR_LINK_STATUS, 16'hF005);
    wr(ADDR_LINK_STATUS, 16'h0000);
    chk_reg(ADDR_LINK_STATUS, 16'hF005);
    // Reflectometry results in their byte lanes.
    peakPositions <= 40'h5A_4B_3C_2D_1E;
    firstPeakAmplitude <= 8'hC3;
    peakPolarity <= 5'h15;
    faultSummary <= 16'hFFFF;
    settle(2);
    chk_reg(ADDR_PEAK_LOW, 16'h2D1E);
    chk_reg(ADDR_PEAK_MID, 16'h4B3C);
    chk_reg(ADDR_PEAK_AMP, 16'hC35A);
    chk_reg(ADDR_PEAK_SIGNS, 16'h0015);
    chk_reg(ADDR_FAULT_SUM, 16'h3FF3);
    wr(ADDR_PEAK_LOW, 16'hFFFF);
    chk_reg(ADDR_PEAK_LOW, 16'h2D1E);
    // Low-power configuration: reserved bits stay zero.
    wr(ADDR_LP_CONFIG, 16'hFE3F);
    chk_reg(ADDR_LP_CONFIG, 16'h003F);
    wr(ADDR_LP_CONFIG, 16'h0100);
    energyLostIn <= 1'b0;
    settle(3);
    chk_out({7'h00, energyDetectEnable}, 8'h01, "energy detect on");
    chk_out({7'h00, sleepEnable}, 8'h00, "sleep barred");
    // Power commands: normal, sleep refused and then allowed, wake, standby.
    wr(ADDR_PWR_CMD, 16'h0001);
    chk_reg(ADDR_PWR_CMD, 16'h0000);
    wait_mode(2'h1);
    sleepRequest <= 1'b1;
    settle(8);
    chk_out({6'h00, powerMode}, 8'h01, "no sleep while barred");
    wr(ADDR_LP_CONFIG, 16'h0180);
    wait_mode(2'h2);
    sleepRequest <= 1'b0;
    wakeRequest <= 1'b1;
    wait_mode(2'h1);
    wakeRequest <= 1'b0;
    wr(ADDR_PWR_CMD, 16'h0010);
    chk_reg(ADDR_PWR_CMD, 16'h0000);
    wait_mode(2'h0);
    chk_reg(ADDR_IRQ_STATUS, 16'h000E);
    // Override: force values replace the device's energy detect, sleep enable and energy lost controls.
    wr(ADDR_LP_CONFIG, 16'h0100);
    wr(ADDR_FORCE_VAL, 16'h0005);
    chk_reg(ADDR_FORCE_VAL, 16'h0005);
    wr(ADDR_FORCE_EN, 16'hFFFF);
    chk_reg(ADDR_FORCE_EN, 16'h01FF);
    settle(3);
    chk_out({5'h00, energyLost, energyDetectEnable, sleepEnable}, 8'h05, "forced");
    wr(ADDR_FORCE_EN, 16'h0000);
    settle(3);
    chk_out({5'h00, energyLost, energyDetectEnable, sleepEnable}, 8'h02, "unforced");
    // Every line-driver swing code from 400 mV to 1200 mV.
    for (int c = 8'h0A; c <= 8'h1E; c++) begin
      wr(ADDR_LD_SWING, {c[5:0], 10'h000});
      settle(2);
      chk_out({2'h0, lineDriverSwingCode}, c[7:0], "swing code");
    end
    chk_reg(ADDR_LD_SWING, 16'h7800);
    // Every serial swing code, the edge rate following its low bit.
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_SER_OUT_CFG, {1'b0, s[1:0], 1'b0, s[0], 11'h002});
      settle(2);
      chk_out({5'h00, serialOutSwingSel, serialOutEdgeRate}, {5'h00, s[1:0], s[0]}, "ser");
      chk_reg(ADDR_SER_OUT_CFG, {1'b0, s[1:0], 1'b0, s[0], 11'h002});
    end
    // Unmapped writes leave nothing behind.
    wr(12'h123, 16'hFFFF);
    chk_reg(12'h123, 16'h0000);
    wrap_up();
  end
endmodule
